// [verilog/ulps_ctrl.sv]
// Low power entry/exit, interface protection and serial mode control
//
// Summary of operation
// RULE_01: Stop high in low power starts start-up, clock restart, then direction falls. Here the clock restarts and direction falls on the same edge.
// RULE_02: Link drops stop only after direction falls, then runs synchronous mode.
// RULE_03: Suspend control bit returns to one by itself on low power exit.
// RULE_04: Stop falling while direction still high is a false resume; re-enter low power.
// RULE_05: Bus driven by link when direction low, device when high, one-cycle turnaround.
// RULE_06: Link drives idle when direction falls, or holds stop high until ready.
// RULE_07: Link drives idle after each receive command turnaround.
// RULE_08: Link should reset with stop high and data tri-stated.
// RULE_09: Weak data pull-downs keep bus from floating; link drive still needed.
// RULE_10: Stop pull-up on at reset; disable bit 7 turns it off.
// RULE_11: Link holds stop low in low power; may disable the pull-up.
// RULE_12: Any stop high level in low power starts wake-up, pull-up included.
// RULE_13: Bus-valid and session-end comparators off only when both edge enables clear.
// RULE_14: Link clears ID-float enables before suspend, re-enables comparators after.
// RULE_15: Interface protection and stop pull-up disabled while reset pin low.
// RULE_16: Serial bit write raises direction, clock stops after five cycles, bus remaps.
// RULE_17: Link programs speed, termination, mode and pull-downs before serial entry.
// RULE_18: Clock stops in serial mode unless keep-clock bit 3 was set.
// RULE_19: Interrupt sources latched before direction rises; mismatch flags an interrupt.
// RULE_20: Stop exits serial; direction falls when ready; reset pulse also exits.
// RULE_21: Three-pin map: enable in, data and SE0 bidirectional, interrupt on line 3.
// RULE_22: Six-pin map: transmit inputs 0..2, interrupt 3, receive 4..6, line 7 low.
// RULE_23: Clearing suspend raises direction, clock low after five edges, then low power.
// RULE_24: Low power map: line state on 1:0, interrupt on 3, rest low.
// RULE_25: Both serial bits set selects six-pin format only.
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "ulps_regs.svh"
module ulps_ctrl
(
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic [3:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_write,
  input  wire logic                      reg_read,
  output logic      [7:0]                reg_rdata,
  input  wire logic                      stop_line,
  input  wire logic [7:0]                data_in,
  input  wire ulps_pkg::ulps_analog_type analog,
  output logic                           direction,
  output logic      [7:0]                data_out,
  output logic      [7:0]                data_oe,
  output logic                           interface_clock_enable,
  output logic                           stop_pullup_enable,
  output logic                           cmp_vbus_session_on,
  output ulps_pkg::ulps_serial_tx_type   serial_tx
);
  ulps_pkg::ulps_state_type state, next_state;
  logic [7:0] func_ctrl, next_func_ctrl;
  logic [7:0] ifc_ctrl, next_ifc_ctrl;
  logic [7:0] int_rise, next_int_rise;
  logic [7:0] int_fall, next_int_fall;
  logic [7:0] count, next_count;
  logic [3:0] latched, next_latched;
  ulps_pkg::ulps_map_type map, next_map;
  logic [7:0] next_rdata;
  logic [3:0] src;
  logic [3:0] unmasked;
  logic       irq;
  logic [7:0] pm_out;
  logic [7:0] pm_oe;
  ulps_pkg::ulps_serial_tx_type pm_tx;

  assign src = {analog.bus_voltage_valid_cmp, analog.session_valid_cmp,
                analog.session_end_cmp, analog.id_ground_cmp};

  generate
    for (genvar i = 0; i < 4; i++)
    begin : g_int
      // Level compare against the pre-entry sample, no clock needed
      assign unmasked[i] = (src[i] & ~latched[i] & int_rise[i])
                         | (~src[i] & latched[i] & int_fall[i]); // RULE_19
    end
  endgenerate
  assign irq = |unmasked;

  ulps_pin_map u_map
  (
    .map      (map),
    .line     (analog),
    .irq      (irq),
    .data_in  (data_in),
    .data_out (pm_out),
    .data_oe  (pm_oe),
    .tx       (pm_tx)
  );

  always_comb
  begin
    next_state     = state;
    next_func_ctrl = func_ctrl;
    next_ifc_ctrl  = ifc_ctrl;
    next_int_rise  = int_rise;
    next_int_fall  = int_fall;
    next_count     = count;
    next_latched   = latched;
    next_map       = map;
    next_rdata     = 8'h00;
    if (reg_read)
    begin
      case (reg_addr)
        `ULPS_ADDR_FUNC_CTRL: next_rdata = func_ctrl;
        `ULPS_ADDR_IFC_CTRL:  next_rdata = ifc_ctrl;
        `ULPS_ADDR_INT_RISE:  next_rdata = int_rise;
        `ULPS_ADDR_INT_FALL:  next_rdata = int_fall;
        `ULPS_ADDR_STATUS:    next_rdata = {5'h00, state};
        default:              next_rdata = 8'h00;
      endcase
    end
    // Writes only land in synchronous mode; every other state drops them, even entry and wait-stop where the clock runs
    if (reg_write && state == ulps_pkg::ULPS_SYNC)
    begin
      case (reg_addr)
        `ULPS_ADDR_FUNC_CTRL: next_func_ctrl = reg_wdata;
        `ULPS_ADDR_IFC_CTRL:  next_ifc_ctrl  = reg_wdata;
        `ULPS_ADDR_INT_RISE:  next_int_rise  = reg_wdata;
        `ULPS_ADDR_INT_FALL:  next_int_fall  = reg_wdata;
        default:              next_int_fall  = int_fall;
      endcase
    end
    case (state)
      ulps_pkg::ULPS_SYNC:
      begin
        next_count = 8'h00;
        if (!func_ctrl[`ULPS_FUNC_SUSPEND_BIT] ||
            ifc_ctrl[`ULPS_IFC_SER6_BIT] || ifc_ctrl[`ULPS_IFC_SER3_BIT])
        begin
          next_state   = ulps_pkg::ULPS_ENTER; // RULE_16 RULE_23
          next_latched = src; // RULE_19
        end
      end
      ulps_pkg::ULPS_ENTER:
      begin
        next_count = count + 8'h01;
        if (count == {4'h0, `ULPS_ENTRY_CYCLES} - 8'h01)
        begin
          if (!func_ctrl[`ULPS_FUNC_SUSPEND_BIT])
          begin
            next_state = ulps_pkg::ULPS_LOWPWR;
            next_map   = ulps_pkg::ULPS_MAP_LOWPWR; // RULE_24
          end
          else
          begin
            next_state = ulps_pkg::ULPS_SERIAL;
            // Six-pin wins when both bits are set
            next_map = ifc_ctrl[`ULPS_IFC_SER6_BIT] ? ulps_pkg::ULPS_MAP_SER6
                                                    : ulps_pkg::ULPS_MAP_SER3; // RULE_25 RULE_21 RULE_22
          end
        end
      end
      ulps_pkg::ULPS_LOWPWR, ulps_pkg::ULPS_SERIAL:
      begin
        next_count = 8'h00;
        if (stop_line)
          next_state = ulps_pkg::ULPS_STARTUP; // RULE_01 RULE_12 RULE_20
      end
      ulps_pkg::ULPS_STARTUP:
      begin
        next_count = count + 8'h01;
        if (!stop_line)
          next_state = ulps_pkg::ULPS_ENTER; // RULE_04
        else if (count == `ULPS_START_CYCLES)
        begin
          next_state = ulps_pkg::ULPS_WAITSTOP; // RULE_01
          next_func_ctrl[`ULPS_FUNC_SUSPEND_BIT] = 1'b1; // RULE_03
          next_ifc_ctrl[`ULPS_IFC_SER6_BIT] = 1'b0; // RULE_20
          next_ifc_ctrl[`ULPS_IFC_SER3_BIT] = 1'b0;
        end
      end
      ulps_pkg::ULPS_WAITSTOP:
      begin
        if (!stop_line)
          next_state = ulps_pkg::ULPS_SYNC; // RULE_02
      end
      default:
        next_state = ulps_pkg::ULPS_SYNC;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state     <= ulps_pkg::ULPS_SYNC; // RULE_20
      func_ctrl <= `ULPS_FUNC_RESET;
      ifc_ctrl  <= `ULPS_IFC_RESET;
      int_rise  <= `ULPS_INT_RESET;
      int_fall  <= `ULPS_INT_RESET;
      count     <= 8'h00;
      latched   <= 4'h0;
      map       <= ulps_pkg::ULPS_MAP_LOWPWR;
      reg_rdata <= 8'h00;
    end
    else
    begin
      state     <= next_state;
      func_ctrl <= next_func_ctrl;
      ifc_ctrl  <= next_ifc_ctrl;
      int_rise  <= next_int_rise;
      int_fall  <= next_int_fall;
      count     <= next_count;
      latched   <= next_latched;
      map       <= next_map;
      reg_rdata <= next_rdata;
    end
  end

  // Pin side, registered; serial pins follow the remap
  logic in_mode;
  assign in_mode = (state == ulps_pkg::ULPS_LOWPWR) || (state == ulps_pkg::ULPS_SERIAL)
                || (state == ulps_pkg::ULPS_STARTUP);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      direction              <= 1'b0;
      data_out               <= 8'h00;
      data_oe                <= 8'h00;
      interface_clock_enable <= 1'b1;
      stop_pullup_enable     <= 1'b0; // RULE_15
      cmp_vbus_session_on    <= 1'b1;
      serial_tx              <= '0;
    end
    else
    begin
      // Direction held through entry, mode and start-up; drops a cycle before bus release
      direction <= (next_state != ulps_pkg::ULPS_SYNC) && (next_state != ulps_pkg::ULPS_WAITSTOP); // RULE_05
      data_out  <= in_mode ? pm_out : 8'h00;
      // Entry drives after the turnaround so the bus never floats under a high direction
      data_oe   <= (state == ulps_pkg::ULPS_ENTER) ? 8'hff : (in_mode ? pm_oe : 8'h00); // RULE_05 RULE_24
      // Inputs ignored outside serial: a pulled-down idle bus decodes as nothing
      serial_tx <= (state == ulps_pkg::ULPS_SERIAL) ? pm_tx : '0; // RULE_09
      // Start-up runs with the clock stopped unless serial mode kept it
      interface_clock_enable <= !((next_state == ulps_pkg::ULPS_LOWPWR) ||
                                  (((next_state == ulps_pkg::ULPS_SERIAL) ||
                                    (next_state == ulps_pkg::ULPS_STARTUP)) && // RULE_01
                                   ((next_map == ulps_pkg::ULPS_MAP_LOWPWR) ||
                                    !ifc_ctrl[`ULPS_IFC_KEEPCLK_BIT]))); // RULE_18
      stop_pullup_enable <= !ifc_ctrl[`ULPS_IFC_PUDIS_BIT]; // RULE_10
      cmp_vbus_session_on <= (int_rise[3] | int_fall[3] | int_rise[1] | int_fall[1]); // RULE_13
    end
  end

  false_resume_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_04
    (state == ulps_pkg::ULPS_STARTUP && !stop_line) |=> state == ulps_pkg::ULPS_ENTER)
    else $error("false resume not taken back to entry");
  suspend_set_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_03
    (state == ulps_pkg::ULPS_WAITSTOP) |-> func_ctrl[`ULPS_FUNC_SUSPEND_BIT])
    else $error("suspend bit not restored");
  entry_len_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_16
    (state == ulps_pkg::ULPS_SYNC ##1 state == ulps_pkg::ULPS_ENTER) |-> state == ulps_pkg::ULPS_ENTER [*5])
    else $error("clock stopped before five cycles");
  stop_wake_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_12
    (state == ulps_pkg::ULPS_LOWPWR && stop_line) |=> state == ulps_pkg::ULPS_STARTUP)
    else $error("stop high did not wake");
  dir_hold_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_23
    (state == ulps_pkg::ULPS_ENTER) |=> direction)
    else $error("direction low during entry");
  both_bits_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_25
    (state == ulps_pkg::ULPS_SERIAL && ifc_ctrl[`ULPS_IFC_SER6_BIT]) |-> map == ulps_pkg::ULPS_MAP_SER6)
    else $error("mixed serial format");
  clk_off_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_18
    (state == ulps_pkg::ULPS_LOWPWR) |-> !interface_clock_enable)
    else $error("clock running in low power");
  pullup_off_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_10
    $rose(ifc_ctrl[`ULPS_IFC_PUDIS_BIT]) |=> !stop_pullup_enable)
    else $error("pull-up not disabled");
  cmp_off_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_13
    (!int_rise[3] && !int_fall[3] && !int_rise[1] && !int_fall[1]) |=> !cmp_vbus_session_on)
    else $error("comparators left on");
  startup_clk_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_01
    (state == ulps_pkg::ULPS_STARTUP && map == ulps_pkg::ULPS_MAP_LOWPWR) |-> !interface_clock_enable)
    else $error("clock restarted before start-up finished");
  dir_release_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_01
    (state == ulps_pkg::ULPS_WAITSTOP) |-> (!direction && interface_clock_enable))
    else $error("direction high or clock stopped after start-up");
  turnaround_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_05
    $rose(direction) |-> (data_oe == 8'h00) ##1 (data_oe == 8'hff))
    else $error("bus turnaround after direction rise wrong");
  serial_clear_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_20
    (state == ulps_pkg::ULPS_WAITSTOP) |-> (!ifc_ctrl[`ULPS_IFC_SER6_BIT] && !ifc_ctrl[`ULPS_IFC_SER3_BIT]))
    else $error("serial mode bits left set after exit");
  serial_wake_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_20
    (state == ulps_pkg::ULPS_SERIAL && stop_line) |=> state == ulps_pkg::ULPS_STARTUP)
    else $error("stop high did not leave serial mode");
  lowpwr_map_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_24
    (state == ulps_pkg::ULPS_LOWPWR ##1 state == ulps_pkg::ULPS_LOWPWR) |->
      (data_oe == 8'hff && data_out[7:4] == 4'h0 && !data_out[2]))
    else $error("low power bus map wrong");
  latch_src_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_19
    (state == ulps_pkg::ULPS_SYNC ##1 state == ulps_pkg::ULPS_ENTER) |-> latched == $past(src))
    else $error("interrupt sources not latched at entry");
  serial_idle_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_09
    (state != ulps_pkg::ULPS_SERIAL) |=> (serial_tx == '0))
    else $error("serial inputs passed outside serial mode");
  cov_lp_c: cover property (@(posedge ref_clk) state == ulps_pkg::ULPS_LOWPWR ##[1:50] state == ulps_pkg::ULPS_SYNC);
  cov_s3_c: cover property (@(posedge ref_clk) map == ulps_pkg::ULPS_MAP_SER3 && state == ulps_pkg::ULPS_SERIAL);
  cov_s6_c: cover property (@(posedge ref_clk) map == ulps_pkg::ULPS_MAP_SER6 && state == ulps_pkg::ULPS_SERIAL);
  cov_fr_c: cover property (@(posedge ref_clk) state == ulps_pkg::ULPS_STARTUP && !stop_line);
  cov_keep_c: cover property (@(posedge ref_clk) state == ulps_pkg::ULPS_SERIAL && interface_clock_enable);
endmodule

// [shared/ulps_regs.svh]
// Offsets, field positions, reset values and timing counts for the low power / serial mode block
`ifndef ULPS_REGS_SVH
`define ULPS_REGS_SVH
`define ULPS_ADDR_FUNC_CTRL      4'h0
`define ULPS_ADDR_IFC_CTRL       4'h1
`define ULPS_ADDR_INT_RISE       4'h2
`define ULPS_ADDR_INT_FALL       4'h3
`define ULPS_ADDR_STATUS         4'h4
`define ULPS_FUNC_SUSPEND_BIT    6
`define ULPS_IFC_SER6_BIT        0
`define ULPS_IFC_SER3_BIT        1
`define ULPS_IFC_KEEPCLK_BIT     3
`define ULPS_IFC_PUDIS_BIT       7
`define ULPS_FUNC_RESET          8'h41
`define ULPS_IFC_RESET           8'h00
`define ULPS_INT_RESET           8'h1f
`define ULPS_ENTRY_CYCLES        4'h5
`define ULPS_START_CYCLES        8'h10
`endif

// [shared/ulps_pkg.sv]
// Types for the low power / serial mode block
package ulps_pkg;
  typedef enum logic [2:0]
  {
    ULPS_SYNC     = 3'b000,
    ULPS_ENTER    = 3'b001,
    ULPS_LOWPWR   = 3'b010,
    ULPS_SERIAL   = 3'b011,
    ULPS_STARTUP  = 3'b100,
    ULPS_WAITSTOP = 3'b101
  } ulps_state_type;

  typedef enum logic [1:0]
  {
    ULPS_MAP_LOWPWR = 2'b00,
    ULPS_MAP_SER3   = 2'b01,
    ULPS_MAP_SER6   = 2'b10
  } ulps_map_type;

  typedef struct packed
  {
    logic plus_line_receive;
    logic minus_line_receive;
    logic diff_receive;
    logic bus_voltage_valid_cmp;
    logic session_valid_cmp;
    logic session_end_cmp;
    logic id_ground_cmp;
  } ulps_analog_type;

  typedef struct packed
  {
    logic       tx_enable;
    logic       tx_data;
    logic       serial_transmit_single_zero;
  } ulps_serial_tx_type;
endpackage

// [verilog/ulps_pin_map.sv]
// Data bus remapping for low power and serial modes
`timescale 1ns/1ps
module ulps_pin_map
(
  input  wire ulps_pkg::ulps_map_type    map,
  input  wire ulps_pkg::ulps_analog_type line,
  input  wire logic                      irq,
  input  wire logic [7:0]                data_in,
  output logic [7:0]                     data_out,
  output logic [7:0]                     data_oe,
  output ulps_pkg::ulps_serial_tx_type   tx
);
  always_comb
  begin
    data_out = 8'h00;
    data_oe  = 8'hff;
    tx       = '0;
    data_out[3] = irq;
    case (map)
      ulps_pkg::ULPS_MAP_SER3:
      begin
        // Lines 1 and 2 turn around with tx enable
        tx.tx_enable = data_in[0];
        data_oe[0]   = 1'b0;
        if (data_in[0])
        begin
          data_oe[2:1]                   = 2'b00;
          tx.tx_data                     = data_in[1];
          tx.serial_transmit_single_zero = data_in[2];
        end
        else
        begin
          data_out[1] = line.diff_receive;
          data_out[2] = ~(line.plus_line_receive | line.minus_line_receive);
        end
      end
      ulps_pkg::ULPS_MAP_SER6:
      begin
        data_oe[2:0]                   = 3'b000;
        tx.tx_enable                   = data_in[0];
        tx.tx_data                     = data_in[1];
        tx.serial_transmit_single_zero = data_in[2];
        data_out[4] = line.plus_line_receive;
        data_out[5] = line.minus_line_receive;
        data_out[6] = line.diff_receive;
      end
      default:
      begin
        data_out[0] = line.plus_line_receive;
        data_out[1] = line.minus_line_receive;
      end
    endcase
  end
endmodule

// [tb/ulps_link_model.sv]
// Link controller model facing the transceiver's stop and data pins
`timescale 1ns/1ps
module ulps_link_model
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       wake,
  input  wire logic       early_drop,
  input  wire logic       float_out,
  input  wire logic [2:0] tx_bits,
  input  wire logic       direction,
  input  wire logic [7:0] data_out,
  input  wire logic [7:0] data_oe,
  input  wire logic       stop_pullup_enable,
  output logic            stop_line,
  output logic [7:0]      data_in
);
  logic       stop_drv;
  logic       stop_last;
  logic       dir_last;
  logic [7:0] link_oe;
  logic [7:0] link_d;

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      stop_drv  <= 1'b1;
      dir_last  <= 1'b0;
      stop_last <= 1'b1;
    end
    else
    begin
      dir_last  <= direction;
      stop_last <= stop_line;
      if (wake)
        stop_drv <= 1'b1;
      else if (!direction || early_drop)
        stop_drv <= 1'b0;
    end
  end

  // Floating stop without pull-up toggles, so a stale level never passes
  assign stop_line = !float_out ? stop_drv : (stop_pullup_enable ? 1'b1 : ~stop_last);
  // Idle only after the turnaround cycle; serial inputs while direction high
  assign link_oe = (float_out || rst) ? 8'h00 :
                   (direction != dir_last) ? 8'h00 : (direction ? ~data_oe : 8'hff);
  assign link_d  = direction ? {5'h00, tx_bits} : 8'h00;
  assign data_in = (data_oe & data_out) | (~data_oe & link_oe & link_d);
endmodule

// [tb/test_ulps_ctrl.sv]
// Self-checking testbench for the low power and serial mode control
`timescale 1ns/1ps
module test_ulps_ctrl;
  logic                         ref_clk = 1'b0;
  logic                         rst = 1'b1;
  logic [3:0]                   reg_addr = 4'h0;
  logic [7:0]                   reg_wdata = 8'h00;
  logic                         reg_write = 1'b0;
  logic                         reg_read = 1'b0;
  logic [7:0]                   reg_rdata;
  logic                         stop_line;
  logic [7:0]                   data_in;
  ulps_pkg::ulps_analog_type    analog = 7'h5c;
  logic                         direction;
  logic [7:0]                   data_out;
  logic [7:0]                   data_oe;
  logic                         clk_en;
  logic                         pu_en;
  logic                         cmp_on;
  ulps_pkg::ulps_serial_tx_type serial_tx;
  logic                         wake = 1'b0;
  logic                         early = 1'b0;
  logic                         flt = 1'b0;
  logic [2:0]                   tx_bits = 3'b101;
  int                           err_count = 0;
  int                           n_checks = 0;
  int                           n;

  always #50 ref_clk = ~ref_clk;

  ulps_ctrl ulps_ctrl_inst (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .stop_line(stop_line),
    .data_in(data_in), .analog(analog), .direction(direction), .data_out(data_out), .data_oe(data_oe),
    .interface_clock_enable(clk_en), .stop_pullup_enable(pu_en), .cmp_vbus_session_on(cmp_on),
    .serial_tx(serial_tx));

  ulps_link_model ulps_link_model_inst (.ref_clk(ref_clk), .rst(rst), .wake(wake), .early_drop(early),
    .float_out(flt), .tx_bits(tx_bits), .direction(direction), .data_out(data_out), .data_oe(data_oe),
    .stop_pullup_enable(pu_en), .stop_line(stop_line), .data_in(data_in));

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask

  // Bounded wait on direction; the count is left in n for timing checks
  task automatic wait_dir(input logic v);
    n = 0;
    while (direction !== v && n < 300)
    begin
      cyc(1);
      n++;
    end
    if (n >= 300)
    begin
      err_count++;
      $display("[FAIL] t=%0t direction stuck, exp=%h", $time, v);
      conclude();
    end
  endtask

  task automatic enter(input logic [3:0] a, input logic [7:0] d, input logic keep);
    int k;
    wr(a, d);
    k = 0;
    do
    begin
      cyc(1);
      k++;
    end
    while (clk_en === 1'b1 && k < 40);
    chk({7'h0, direction}, 8'h01);
    chk({7'h0, clk_en}, {7'h0, keep});
    if (!keep)
      chk({7'h0, k >= 5}, 8'h01);
    // Bus map and turnaround settle two cycles after the clock stops
    cyc(2);
  endtask

  task automatic wake_up();
    @(posedge ref_clk);
    wake <= 1'b1;
    wait_dir(1'b0);
    chk({7'h0, n >= 16}, 8'h01);
    chk({7'h0, clk_en}, 8'h01);
    @(posedge ref_clk);
    wake <= 1'b0;
    cyc(3);
    rd(4'h0, 8'h41);
  endtask

  task automatic an(input ulps_pkg::ulps_analog_type v);
    @(posedge ref_clk);
    analog <= v;
    cyc(2);
  endtask

  initial
  begin
    cyc(2);
    chk({4'h0, direction, clk_en, pu_en, cmp_on}, 8'h05);
    chk(data_oe, 8'h00);
    @(posedge ref_clk);
    rst <= 1'b0;
    cyc(1);
    chk({7'h0, pu_en}, 8'h01);
    rd(4'h0, 8'h41);
    rd(4'h1, 8'h00);
    rd(4'h2, 8'h1f);
    rd(4'h3, 8'h1f);
    rd(4'h5, 8'h00);
    rd(4'h4, 8'h00);
    $display("test reset done");
    enter(4'h0, 8'h01, 1'b0);
    chk(data_oe, 8'hff);
    chk(data_out, 8'h01);
    chk({7'h0, cmp_on}, 8'h01);
    an(7'h7c);
    chk(data_out, 8'h03);
    an(7'h7d);
    chk(data_out, 8'h0b);
    an(7'h5c);
    chk(data_out, 8'h01);
    wake_up();
    // Stop dropped while direction still high must fall back asleep
    enter(4'h0, 8'h01, 1'b0);
    wake <= 1'b1;
    cyc(4);
    wake <= 1'b0;
    early <= 1'b1;
    cyc(40);
    chk({6'h0, direction, clk_en}, 8'h02);
    early <= 1'b0;
    wake_up();
    enter(4'h0, 8'h01, 1'b0);
    flt <= 1'b1;
    wait_dir(1'b0);
    chk({7'h0, clk_en}, 8'h01);
    flt <= 1'b0;
    cyc(3);
    wr(4'h1, 8'h80);
    cyc(1);
    chk({7'h0, pu_en}, 8'h00);
    rd(4'h1, 8'h80);
    $display("test low power done");
    wr(4'h2, 8'h15);
    enter(4'h0, 8'h01, 1'b0);
    chk({7'h0, cmp_on}, 8'h01);
    wake_up();
    wr(4'h3, 8'h15);
    enter(4'h0, 8'h01, 1'b0);
    chk({7'h0, cmp_on}, 8'h00);
    wake_up();
    wr(4'h2, 8'h1f);
    wr(4'h3, 8'h1f);
    cyc(1);
    chk({7'h0, cmp_on}, 8'h01);
    $display("test comparators done");
    enter(4'h1, 8'h01, 1'b0);
    chk(data_oe, 8'hf8);
    chk(data_out & 8'hf8, 8'h50);
    chk({5'h0, serial_tx}, 8'h05);
    wake_up();
    rd(4'h1, 8'h00);
    chk({5'h0, serial_tx}, 8'h00);
    enter(4'h1, 8'h0a, 1'b1);
    chk(data_oe, 8'hf8);
    chk({5'h0, serial_tx}, 8'h05);
    @(posedge ref_clk);
    tx_bits <= 3'b000;
    cyc(2);
    chk(data_oe, 8'hfe);
    chk(data_out & 8'hfa, 8'h02);
    wake_up();
    enter(4'h1, 8'h03, 1'b0);
    chk(data_oe, 8'hf8);
    @(posedge ref_clk);
    rst <= 1'b1;
    #1;
    chk({6'h0, direction, pu_en}, 8'h00);
    @(posedge ref_clk);
    rst <= 1'b0;
    cyc(2);
    chk({7'h0, direction}, 8'h00);
    rd(4'h1, 8'h00);
    $display("test serial done");
    conclude();
  end
endmodule
